//--- pfcc_command.sv
`timescale 1ns/1ps
module pfcc_command (
  input wire logic clk,
  input wire logic srst,
  input wire logic cfg_access,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_offset,
  input wire logic [1:0] cfg_byte_en,
  input wire logic [15:0] cfg_wdata,
  input wire logic mem_access,
  input wire logic io_access,
  input wire logic master_request,
  input wire logic mwi_request,
  input wire logic b2b_request,
  input wire logic b2b_same_agent,
  input wire logic drive_cycle,
  input wire logic [31:0] drive_data,
  input wire logic [3:0] drive_cbe,
  input wire logic data_parity_error,
  input wire logic addr_parity_error,
  input wire logic detected_parity_clear,
  output logic [15:0] cfg_rdata,
  output logic mem_claim,
  output logic io_claim,
  output logic master_grant,
  output logic mwi_grant,
  output logic b2b_grant,
  output logic par_out,
  output logic perr_out,
  output logic perr_oe,
  output logic serr_n_out,
  output logic serr_n_oe,
  output logic detected_parity_error_flag
);

  ////////////////////////////////////////////////////////////////////////////////
  pfcc_cfg_if cfg_bus ();
  logic [15:0] cmd;
  logic hit;
  logic perr_assert;
  logic serr_assert;
  logic next_mem_claim;
  logic next_io_claim;
  logic next_master;
  logic next_mwi;
  logic next_b2b;
  logic next_par;
  logic next_parity_flag;
  logic parity_response_on;
  logic system_error_on;

  function automatic logic cmd_bit(input logic [15:0] value, input int idx);
    cmd_bit = value[idx];
  endfunction : cmd_bit

  assign hit = cfg_access && (cfg_offset == pfcc_pkg::CMD_OFFSET);
  assign cfg_bus.wr = hit && cfg_write;
  assign cfg_bus.byte_en = cfg_byte_en;
  assign cfg_bus.wdata = cfg_wdata;
  assign cmd = cfg_bus.value;
  assign parity_response_on = cmd_bit(cmd, pfcc_pkg::BIT_PARITY_RESPONSE);
  assign system_error_on = cmd_bit(cmd, pfcc_pkg::BIT_SYSTEM_ERROR);

  pfcc_reg_bank u_bank (
    .clk(clk),
    .srst(srst),
    .cfg(cfg_bus)
  );

  pfcc_parity_ctl u_parity (
    .clk(clk),
    .srst(srst),
    .parity_enable(parity_response_on),
    .serr_enable(system_error_on),
    .data_parity_error(data_parity_error),
    .addr_parity_error(addr_parity_error),
    .perr_assert(perr_assert),
    .serr_assert(serr_assert)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // An all-zero register clears every enable, so only configuration cycles remain.
  assign next_mem_claim = mem_access && cmd_bit(cmd, pfcc_pkg::BIT_MEM_SPACE);
  assign next_io_claim = io_access && cmd_bit(cmd, pfcc_pkg::BIT_IO_SPACE);
  assign next_master = master_request && cmd_bit(cmd, pfcc_pkg::BIT_BUS_MASTER);
  assign next_mwi = next_master && mwi_request
                    && cmd_bit(cmd, pfcc_pkg::BIT_WRITE_INVALIDATE);
  assign next_b2b = next_master && b2b_request
                    && (b2b_same_agent || cmd_bit(cmd, pfcc_pkg::BIT_FAST_B2B));
  // Parity is produced regardless of the parity response bit.
  assign next_par = drive_cycle ? ^{drive_data, drive_cbe} : 1'b0;
  // Set wins over a simultaneous clear so no error is lost.
  assign next_parity_flag = (data_parity_error || addr_parity_error)
                    || (detected_parity_error_flag && !detected_parity_clear);

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_rdata <= 16'h0000;
      mem_claim <= 1'b0;
      io_claim <= 1'b0;
      master_grant <= 1'b0;
      mwi_grant <= 1'b0;
      b2b_grant <= 1'b0;
      par_out <= 1'b0;
      detected_parity_error_flag <= 1'b0;
    end else begin
      cfg_rdata <= hit ? cmd : 16'h0000;
      mem_claim <= next_mem_claim;
      io_claim <= next_io_claim;
      master_grant <= next_master;
      mwi_grant <= next_mwi;
      b2b_grant <= next_b2b;
      par_out <= next_par;
      detected_parity_error_flag <= next_parity_flag;
    end
  end

  // Special cycles and palette writes have no path here; they are never snooped.
  always_ff @(posedge clk) begin
    if (srst) begin
      perr_out <= 1'b0;
      perr_oe <= 1'b0;
      serr_n_out <= 1'b1;
      serr_n_oe <= 1'b0;
    end else begin
      perr_out <= 1'b0;
      perr_oe <= perr_assert;
      serr_n_out <= 1'b0;
      // Open-drain: driver only enabled with the system error enable bit.
      serr_n_oe <= serr_assert && system_error_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_zero_detach: assert property (@(posedge clk) disable iff (srst)
    (cmd == 16'h0000) && !$past(srst) |=> !mem_claim && !io_claim && !master_grant)
    else $error("detached function responded");

  a_serr_gated: assert property (@(posedge clk) disable iff (srst)
    serr_n_oe |-> $past(cmd[8]))
    else $error("system error driven while disabled");

  a_perr_gated: assert property (@(posedge clk) disable iff (srst)
    data_parity_error && !cmd[6] |-> ##2 !perr_oe)
    else $error("parity error output while response off");

  a_parity_flag_sets: assert property (@(posedge clk) disable iff (srst)
    data_parity_error |=> detected_parity_error_flag)
    else $error("detected parity flag not set");

  a_b2b_agent: assert property (@(posedge clk) disable iff (srst)
    b2b_grant |-> $past(b2b_same_agent) || $past(cmd[9]))
    else $error("fast back-to-back to other agent");

  a_mwi_enable: assert property (@(posedge clk) disable iff (srst)
    mwi_grant |-> $past(cmd[4]) && $past(cmd[2]))
    else $error("write and invalidate without enable");

  a_parity_gen: assert property (@(posedge clk) disable iff (srst)
    drive_cycle |=> par_out == ^{$past(drive_data), $past(drive_cbe)})
    else $error("wrong parity generated");

  a_mem_gate: assert property (@(posedge clk) disable iff (srst)
    mem_claim |-> $past(cmd[1]) && $past(mem_access))
    else $error("memory claim while disabled");

  a_rdata_ro: assert property (@(posedge clk) disable iff (srst)
    cfg_rdata[7] == 1'b0 && cfg_rdata[5] == 1'b0 && cfg_rdata[3] == 1'b0)
    else $error("read-only bit read as one");

  a_io_gate: assert property (@(posedge clk) disable iff (srst)
    io_claim |-> $past(cmd[0]) && $past(io_access))
    else $error("io claim while disabled");

  a_master_gate: assert property (@(posedge clk) disable iff (srst)
    master_grant |-> $past(cmd[2]) && $past(master_request))
    else $error("master grant while disabled");

  a_io_blocked: assert property (@(posedge clk) disable iff (srst)
    !cmd[0] |=> !io_claim)
    else $error("io claim with io space off");

  a_master_blocked: assert property (@(posedge clk) disable iff (srst)
    !cmd[2] |=> !master_grant && !mwi_grant && !b2b_grant)
    else $error("master activity with bus master off");

  a_mwi_blocked: assert property (@(posedge clk) disable iff (srst)
    !cmd[4] |=> !mwi_grant)
    else $error("write and invalidate with enable off");

  a_b2b_block: assert property (@(posedge clk) disable iff (srst)
    !b2b_same_agent && !cmd[9] |=> !b2b_grant)
    else $error("back-to-back to other agent with bit 9 clear");

  ////////////////////////////////////////////////////////////////////////////////
  // Positive checks: a gate that never opens would pass every blocking check above.
  a_mem_follows: assert property (@(posedge clk) disable iff (srst)
    mem_access && cmd[1] |=> mem_claim)
    else $error("enabled memory access not claimed");

  a_io_follows: assert property (@(posedge clk) disable iff (srst)
    io_access && cmd[0] |=> io_claim)
    else $error("enabled io access not claimed");

  a_master_follows: assert property (@(posedge clk) disable iff (srst)
    master_request && cmd[2] |=> master_grant)
    else $error("enabled master request not granted");

  a_mwi_follows: assert property (@(posedge clk) disable iff (srst)
    master_request && mwi_request && cmd[2] && cmd[4] |=> mwi_grant)
    else $error("enabled write and invalidate not granted");

  a_b2b_same: assert property (@(posedge clk) disable iff (srst)
    master_request && b2b_request && cmd[2] && b2b_same_agent |=> b2b_grant)
    else $error("same-agent back-to-back not granted");

  a_perr_timing: assert property (@(posedge clk) disable iff (srst)
    data_parity_error && cmd[6] |-> ##2 perr_oe)
    else $error("parity error output missing");

  a_perr_cause: assert property (@(posedge clk) disable iff (srst)
    perr_oe |-> $past(data_parity_error, 2) && $past(cmd[6], 2))
    else $error("parity error output without cause");

  // Bit 8 is looked at twice, so a late clear of it must suppress the pin.
  a_serr_timing: assert property (@(posedge clk) disable iff (srst)
    addr_parity_error && cmd[8] && cmd[6] ##1 cmd[8] |-> ##1 serr_n_oe)
    else $error("system error output missing");

  a_serr_blocked: assert property (@(posedge clk) disable iff (srst)
    addr_parity_error && !(cmd[8] && cmd[6]) |-> ##2 !serr_n_oe)
    else $error("system error without both enables");

  a_serr_cause: assert property (@(posedge clk) disable iff (srst)
    serr_n_oe |-> $past(addr_parity_error, 2) && $past(cmd[6], 2))
    else $error("system error output without cause");

  a_flag_addr: assert property (@(posedge clk) disable iff (srst)
    addr_parity_error |=> detected_parity_error_flag)
    else $error("address parity error not flagged");

  a_flag_hold: assert property (@(posedge clk) disable iff (srst)
    detected_parity_error_flag && !detected_parity_clear |=> detected_parity_error_flag)
    else $error("detected parity flag lost");

  a_flag_clear: assert property (@(posedge clk) disable iff (srst)
    detected_parity_clear && !data_parity_error && !addr_parity_error
    |=> !detected_parity_error_flag)
    else $error("detected parity flag not cleared");

  a_par_idle: assert property (@(posedge clk) disable iff (srst)
    !drive_cycle |=> !par_out)
    else $error("parity driven on idle cycle");

  a_rdata_value: assert property (@(posedge clk) disable iff (srst)
    hit |=> cfg_rdata == $past(cmd))
    else $error("command read returned wrong value");

  a_rdata_miss: assert property (@(posedge clk) disable iff (srst)
    !hit |=> cfg_rdata == 16'h0000)
    else $error("read data without command hit");

  a_write_lands: assert property (@(posedge clk) disable iff (srst)
    hit && cfg_write && (cfg_byte_en == 2'b11)
    |=> cmd == ($past(cfg_wdata) & pfcc_pkg::CMD_WRITE_MASK))
    else $error("full write stored wrong value");

  a_low_lane_hold: assert property (@(posedge clk) disable iff (srst)
    hit && cfg_write && !cfg_byte_en[0] |=> cmd[7:0] == $past(cmd[7:0]))
    else $error("disabled lower lane changed");

  // Reset checks carry no disable, so the reset branch itself is watched.
  a_cmd_reset: assert property (@(posedge clk)
    srst |=> cmd == pfcc_pkg::CMD_RESET)
    else $error("command not cleared by reset");

  a_reset_outputs: assert property (@(posedge clk)
    srst |=> cfg_rdata == 16'h0000 && !mem_claim && !io_claim && !master_grant
             && !perr_oe && serr_n_out && !serr_n_oe && !detected_parity_error_flag)
    else $error("outputs not at reset value");

  c_master: cover property (@(posedge clk) master_grant);
  c_serr: cover property (@(posedge clk) serr_n_oe);
  c_perr: cover property (@(posedge clk) perr_oe);
  c_b2b_other: cover property (@(posedge clk) b2b_grant && !$past(b2b_same_agent));
  c_mwi: cover property (@(posedge clk) mwi_grant);

endmodule : pfcc_command

//--- pfcc_pkg.sv
package pfcc_pkg;

  localparam int REG_WIDTH = 16;
  localparam logic [7:0] CMD_OFFSET = 8'h04;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // Bits that keep a written value; bits 7, 5 and 3 stay zero.
  localparam logic [15:0] CMD_WRITE_MASK = 16'hFF57;
  localparam int BIT_IO_SPACE = 0;
  localparam int BIT_MEM_SPACE = 1;
  localparam int BIT_BUS_MASTER = 2;
  localparam int BIT_SPECIAL_CYCLE = 3;
  localparam int BIT_WRITE_INVALIDATE = 4;
  localparam int BIT_PALETTE_SNOOP = 5;
  localparam int BIT_PARITY_RESPONSE = 6;
  localparam int BIT_STEPPING = 7;
  localparam int BIT_SYSTEM_ERROR = 8;
  localparam int BIT_FAST_B2B = 9;
  localparam int STAT_DETECTED_PARITY = 15;

endpackage : pfcc_pkg

//--- pfcc_cfg_if.sv
`timescale 1ns/1ps
interface pfcc_cfg_if;
  logic wr;
  logic [1:0] byte_en;
  logic [15:0] wdata;
  logic [15:0] value;

  modport bank (
    input wr,
    input byte_en,
    input wdata,
    output value
  );
  modport ctrl (
    output wr,
    output byte_en,
    output wdata,
    input value
  );
endinterface : pfcc_cfg_if

//--- pfcc_reg_bank.sv
`timescale 1ns/1ps
module pfcc_reg_bank (
  input wire logic clk,
  input wire logic srst,
  pfcc_cfg_if.bank cfg
);

  logic [15:0] cmd;
  logic [15:0] lane_mask;
  logic [15:0] next_cmd;

  // Only enabled lanes and writable bits take the new value.
  assign lane_mask = {{8{cfg.byte_en[1]}}, {8{cfg.byte_en[0]}}}
                     & pfcc_pkg::CMD_WRITE_MASK;
  assign next_cmd = (cmd & ~lane_mask) | (cfg.wdata & lane_mask);
  assign cfg.value = cmd;

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd <= pfcc_pkg::CMD_RESET;
    end else if (cfg.wr) begin
      cmd <= next_cmd;
    end
  end

  a_readonly_zero: assert property (@(posedge clk) disable iff (srst)
    (cmd[7] == 1'b0) && (cmd[5] == 1'b0) && (cmd[3] == 1'b0))
    else $error("read-only command bit is set");

  a_lane_hold: assert property (@(posedge clk) disable iff (srst)
    cfg.wr && !cfg.byte_en[1] |=> cmd[15:8] == $past(cmd[15:8]))
    else $error("disabled upper lane changed");

endmodule : pfcc_reg_bank

//--- pfcc_parity_ctl.sv
`timescale 1ns/1ps
module pfcc_parity_ctl (
  input wire logic clk,
  input wire logic srst,
  input wire logic parity_enable,
  input wire logic serr_enable,
  input wire logic data_parity_error,
  input wire logic addr_parity_error,
  output logic perr_assert,
  output logic serr_assert
);

  logic next_perr;
  logic next_serr;

  assign next_perr = parity_enable & data_parity_error;
  assign next_serr = serr_enable & parity_enable & addr_parity_error;

  always_ff @(posedge clk) begin
    if (srst) begin
      perr_assert <= 1'b0;
      serr_assert <= 1'b0;
    end else begin
      perr_assert <= next_perr;
      serr_assert <= next_serr;
    end
  end

  a_serr_needs_both: assert property (@(posedge clk) disable iff (srst)
    serr_assert |-> $past(serr_enable) && $past(parity_enable))
    else $error("system error without both enables");

endmodule : pfcc_parity_ctl

//--- pfcc_host_model.sv
`timescale 1ns/1ps
// Configuration software side: one access per call, held for exactly one edge.
module pfcc_host_model (
  input wire logic clk,
  output logic cfg_access,
  output logic cfg_write,
  output logic [7:0] cfg_offset,
  output logic [1:0] cfg_byte_en,
  output logic [15:0] cfg_wdata,
  input wire logic [15:0] cfg_rdata
);
  initial begin
    cfg_access = 1'b0;
    cfg_write = 1'b0;
    cfg_offset = 8'h00;
    cfg_byte_en = 2'b00;
    cfg_wdata = 16'h0000;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic wr, input logic [7:0] off, input logic [1:0] be,
                      input logic [15:0] d, input bit raw, output logic [15:0] rd);
    @(posedge clk);
    cfg_access <= 1'b1;
    cfg_write <= wr;
    cfg_offset <= off;
    cfg_byte_en <= be;
    cfg_wdata <= raw ? d : (d & 16'h03FF);
    @(posedge clk);
    // Released write, offset and data lines show the inverse (byte enables keep their value) so that stale data cannot pass as valid.
    cfg_access <= 1'b0;
    cfg_write <= ~wr;
    cfg_offset <= ~off;
    cfg_wdata <= ~d;
    #1;
    rd = cfg_rdata;
  endtask : xfer
endmodule : pfcc_host_model

//--- testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cfg_access, cfg_write;
  logic [7:0] cfg_offset;
  logic [1:0] cfg_byte_en;
  logic [15:0] cfg_wdata, cfg_rdata, rd;
  logic mem_access, io_access, master_request, mwi_request, b2b_request, b2b_same_agent;
  logic drive_cycle, data_parity_error, addr_parity_error, detected_parity_clear;
  logic [31:0] drive_data;
  logic [3:0] drive_cbe;
  logic mem_claim, io_claim, master_grant, mwi_grant, b2b_grant, par_out;
  logic perr_out, perr_oe, serr_n_out, serr_n_oe, detected_parity_error_flag;
  logic [15:0] cmds [5] = '{16'h0001, 16'h0002, 16'h0004, 16'h0014, 16'h0204};
  logic [4:0] gates [5] = '{5'b10000, 5'b01000, 5'b00100, 5'b00110, 5'b00101};
  logic [15:0] pcmd [5] = '{16'h0040, 16'h0000, 16'h0140, 16'h0100, 16'h0040};
  logic [4:0] pexp [5] = '{5'b10001, 5'b00001, 5'b00101, 5'b00001, 5'b00001};
  int n_fail = 0;
  int samples_checked = 0;
  always #2 clk = ~clk;
  pfcc_command u_pfcc_command (.clk, .srst, .cfg_access, .cfg_write, .cfg_offset,
    .cfg_byte_en, .cfg_wdata, .mem_access, .io_access, .master_request, .mwi_request,
    .b2b_request, .b2b_same_agent, .drive_cycle, .drive_data, .drive_cbe,
    .data_parity_error, .addr_parity_error, .detected_parity_clear, .cfg_rdata,
    .mem_claim, .io_claim, .master_grant, .mwi_grant, .b2b_grant, .par_out, .perr_out,
    .perr_oe, .serr_n_out, .serr_n_oe, .detected_parity_error_flag);
  pfcc_host_model u_pfcc_host_model (.clk, .cfg_access, .cfg_write, .cfg_offset,
    .cfg_byte_en, .cfg_wdata, .cfg_rdata);
  //////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [15:0] d, input logic [1:0] be, input bit raw);
    u_pfcc_host_model.xfer(1'b1, 8'h04, be, d, raw, rd);
  endtask : wr
  task automatic rdreg(input logic [7:0] off);
    u_pfcc_host_model.xfer(1'b0, off, 2'b11, 16'h0000, 1'b0, rd);
  endtask : rdreg
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic end_of_test();
    $display("TB: checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {mem_access, io_access, master_request, mwi_request, b2b_request} = 5'h1f;
    {b2b_same_agent, drive_cycle, data_parity_error, addr_parity_error} = 4'h0;
    {detected_parity_clear, drive_data, drive_cbe} = '0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    settle(1);
    `CHK({mem_claim, io_claim, master_grant, mwi_grant, b2b_grant}, 5'b0)
    rdreg(8'h04);
    `CHK(rd, 16'h0000)
    wr(16'hFFFF, 2'b11, 1'b1);
    rdreg(8'h04);
    `CHK(rd, 16'hFF57)
    rdreg(8'h06);
    `CHK(rd, 16'h0000)
    wr(16'h0000, 2'b01, 1'b1);
    rdreg(8'h04);
    `CHK(rd, 16'hFF00)
    wr(16'h0000, 2'b10, 1'b0);
    rdreg(8'h04);
    `CHK(rd, 16'h0000)
    // All targets are taken as capable, so bit 9 may be set here.
    for (int i = 0; i < 5; i++) begin
      wr(cmds[i], 2'b11, 1'b0);
      settle(2);
      `CHK({io_claim, mem_claim, master_grant, mwi_grant, b2b_grant},
           gates[i])
    end
    // Bit 9 clear again, so only the same-agent path can grant.
    wr(16'h0004, 2'b11, 1'b0);
    @(posedge clk);
    b2b_same_agent <= 1'b1;
    settle(2);
    `CHK(b2b_grant, 1'b1)
    for (int i = 0; i < 5; i++) begin
      wr(pcmd[i], 2'b11, 1'b0);
      @(posedge clk);
      data_parity_error <= (i < 2);
      addr_parity_error <= (i >= 2);
      @(posedge clk);
      {data_parity_error, addr_parity_error} <= 2'b00;
      // The error outputs stand for one cycle only, two edges after the error.
      settle(1);
      `CHK({perr_oe, perr_out, serr_n_oe, serr_n_out, detected_parity_error_flag},
           pexp[i])
      @(posedge clk);
      detected_parity_clear <= 1'b1;
      @(posedge clk);
      detected_parity_clear <= 1'b0;
      settle(1);
      `CHK(detected_parity_error_flag, 1'b0)
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      drive_cycle <= 1'b1;
      drive_data <= i ? 32'hA5A5_0F01 : 32'h0000_0001;
      drive_cbe <= i ? 4'h7 : 4'h0;
      settle(1);
      `CHK(par_out, ^{drive_data, drive_cbe})
    end
    @(posedge clk);
    drive_cycle <= 1'b0;
    settle(1);
    `CHK(par_out, 1'b0)
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    `CHK({serr_n_out, serr_n_oe, cfg_rdata}, {1'b1, 1'b0, 16'h0000})
    rdreg(8'h04);
    `CHK(rd, 16'h0000)
    end_of_test();
  end
  // The whole sequence needs about a hundred cycles; this bound leaves wide margin.
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
endmodule : testbench
